/* iob_pkg.sv */
package iob_pkg;
  // instruction field layout
  localparam int OPC_LSB = 9;
  localparam int DEV_LSB = 3;
  localparam int DEV_MSB = 8;
  localparam int SEL_P1_BIT = 0;
  localparam int SEL_P2_BIT = 1;
  localparam int SEL_P4_BIT = 2;
  localparam logic [2:0] IOT_OPCODE = 3'h6;
  // interrupt control instructions (octal 6001 and 6002)
  localparam logic [11:0] INT_ON_INSTR = 12'hc01;
  localparam logic [11:0] INT_OFF_INSTR = 12'hc02;
  // interrupt vectors: octal 0000/0001 and 0040/0041
  localparam logic [11:0] PRI_SAVE_ADDR = 12'h000;
  localparam logic [11:0] PRI_START_ADDR = 12'h001;
  localparam logic [11:0] ALT_SAVE_ADDR = 12'h020;
  localparam logic [11:0] ALT_START_ADDR = 12'h021;
  // pulse timing
  localparam int CLK_MHZ = 100;
  localparam int IOP_WIDTH_NS = 500;
  localparam int IOP_GAP_NS = 500;
  localparam int IOP_WIDTH_CYC = (IOP_WIDTH_NS * CLK_MHZ + 999) / 1000;
  localparam int IOP_GAP_CYC = (IOP_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] IOP_WIDTH_LOAD = CNT_W'(IOP_WIDTH_CYC - 1);
  localparam logic [CNT_W-1:0] IOP_GAP_LOAD = CNT_W'(IOP_GAP_CYC - 1);
  // reset values
  localparam logic [11:0] WORD_RST = 12'h000;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

  // opcode decode used by the processor end
  function automatic logic is_iot(input logic [11:0] word);
    is_iot = (word[11:OPC_LSB] == IOT_OPCODE);
  endfunction
endpackage

/* iob_if.sv */
`timescale 1ns/1ns
interface iob_if;
  logic [11:0] instr;
  logic biop1;
  logic biop2;
  logic biop4;
  logic [11:0] ac_out;
  logic [11:0] data_in;
  logic skip;
  logic int_req;

  modport proc (
    output instr,
    output biop1,
    output biop2,
    output biop4,
    output ac_out,
    input data_in,
    input skip,
    input int_req
  );

  modport periph (
    input instr,
    input biop1,
    input biop2,
    input biop4,
    input ac_out,
    output data_in,
    output skip,
    output int_req
  );
endinterface

/* iob_proc.sv */
`timescale 1ns/1ns
module iob_proc (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // bus side
  iob_if.proc bus,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [11:0] instr,
  input wire logic [11:0] pc,
  input wire logic [11:0] accumulator,
  input wire logic alternate_mode,
  output logic instr_ready_q,
  output logic done_q,
  output logic skip_q,
  output logic acc_load_q,
  output logic [11:0] acc_in_q,
  // interrupt jump
  output logic int_jump_q,
  output logic [11:0] save_addr_q,
  output logic [11:0] save_data_q,
  output logic [11:0] pc_load_q,
  output logic int_enable_q
);
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_P1 = 8'h02,
    ST_G1 = 8'h04,
    ST_P2 = 8'h08,
    ST_G2 = 8'h10,
    ST_P4 = 8'h20,
    ST_G4 = 8'h40,
    ST_INT = 8'h80
  } iob_state_e;

  iob_state_e state_q, state_d;
  logic [iob_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [11:0] instr_q, instr_d;
  logic [11:0] ac_out_q, ac_out_d;
  logic biop1_q, biop1_d;
  logic biop2_q, biop2_d;
  logic biop4_q, biop4_d;
  logic skip_acc_q, skip_acc_d;
  logic [11:0] data_acc_q, data_acc_d;
  logic instr_ready_d, done_d, skip_d, acc_load_d;
  logic [11:0] acc_in_d;
  logic int_jump_d;
  logic [11:0] save_addr_d, save_data_d, pc_load_d;
  logic int_enable_d;
  logic cnt_zero;

  assign cnt_zero = (cnt_q == iob_pkg::CNT_RST);

  // bus pins come straight from flops
  assign bus.instr = instr_q;
  assign bus.ac_out = ac_out_q;
  assign bus.biop1 = biop1_q;
  assign bus.biop2 = biop2_q;
  assign bus.biop4 = biop4_q;

  // sequencer: interrupt is checked before a new instruction is taken
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    instr_d = instr_q;
    ac_out_d = ac_out_q;
    skip_acc_d = skip_acc_q;
    data_acc_d = data_acc_q;
    done_d = 1'b0;
    skip_d = skip_q;
    acc_load_d = 1'b0;
    acc_in_d = acc_in_q;
    int_jump_d = 1'b0;
    save_addr_d = save_addr_q;
    save_data_d = save_data_q;
    pc_load_d = pc_load_q;
    int_enable_d = int_enable_q;
    unique case (state_q)
      ST_IDLE: begin
        if (int_enable_q && bus.int_req) begin
          state_d = ST_INT;
          int_enable_d = 1'b0;
        end else if (instr_valid) begin
          if (iob_pkg::is_iot(instr)) begin
            instr_d = instr;
            ac_out_d = accumulator;
            skip_acc_d = 1'b0;
            data_acc_d = iob_pkg::WORD_RST;
            cnt_d = iob_pkg::IOP_WIDTH_LOAD;
            state_d = ST_P1;
            if (instr == iob_pkg::INT_ON_INSTR) begin
              int_enable_d = 1'b1;
            end else if (instr == iob_pkg::INT_OFF_INSTR) begin
              int_enable_d = 1'b0;
            end
          end else begin
            // not for this bus: finish at once, no pulses
            done_d = 1'b1;
            skip_d = 1'b0;
          end
        end
      end
      ST_P1: begin
        skip_acc_d = skip_acc_q | bus.skip;
        if (cnt_zero) begin
          cnt_d = iob_pkg::IOP_GAP_LOAD;
          state_d = ST_G1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_G1: begin
        // peripheral answers one cycle late, so keep listening in the gap
        skip_acc_d = skip_acc_q | bus.skip;
        if (cnt_zero) begin
          cnt_d = iob_pkg::IOP_WIDTH_LOAD;
          state_d = ST_P2;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_P2: begin
        if (cnt_zero) begin
          cnt_d = iob_pkg::IOP_GAP_LOAD;
          state_d = ST_G2;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_G2: begin
        if (cnt_zero) begin
          cnt_d = iob_pkg::IOP_WIDTH_LOAD;
          state_d = ST_P4;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_P4: begin
        data_acc_d = data_acc_q | bus.data_in;
        if (cnt_zero) begin
          cnt_d = iob_pkg::IOP_GAP_LOAD;
          state_d = ST_G4;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_G4: begin
        data_acc_d = data_acc_q | bus.data_in;
        if (cnt_zero) begin
          // pause ends only after the third pulse and its gap
          state_d = ST_IDLE;
          done_d = 1'b1;
          skip_d = skip_acc_d;
          if (instr_q[iob_pkg::SEL_P4_BIT]) begin
            acc_load_d = 1'b1;
            acc_in_d = data_acc_d;
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_INT: begin
        // old pc goes to the save word so a jump through it resumes
        int_jump_d = 1'b1;
        save_data_d = pc;
        if (alternate_mode) begin
          save_addr_d = iob_pkg::ALT_SAVE_ADDR;
          pc_load_d = iob_pkg::ALT_START_ADDR;
        end else begin
          save_addr_d = iob_pkg::PRI_SAVE_ADDR;
          pc_load_d = iob_pkg::PRI_START_ADDR;
        end
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // pulses run in every iot; selection only decides what reaches the bus
  always_comb begin
    biop1_d = (state_d == ST_P1) && instr_d[iob_pkg::SEL_P1_BIT];
    biop2_d = (state_d == ST_P2) && instr_d[iob_pkg::SEL_P2_BIT];
    biop4_d = (state_d == ST_P4) && instr_d[iob_pkg::SEL_P4_BIT];
    instr_ready_d = (state_d == ST_IDLE) && !(int_enable_d && bus.int_req);
  end

  // state registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cnt_q <= iob_pkg::CNT_RST;
      instr_q <= iob_pkg::WORD_RST;
      ac_out_q <= iob_pkg::WORD_RST;
      biop1_q <= 1'b0;
      biop2_q <= 1'b0;
      biop4_q <= 1'b0;
      skip_acc_q <= 1'b0;
      data_acc_q <= iob_pkg::WORD_RST;
      instr_ready_q <= 1'b0;
      done_q <= 1'b0;
      skip_q <= 1'b0;
      acc_load_q <= 1'b0;
      acc_in_q <= iob_pkg::WORD_RST;
      int_jump_q <= 1'b0;
      save_addr_q <= iob_pkg::WORD_RST;
      save_data_q <= iob_pkg::WORD_RST;
      pc_load_q <= iob_pkg::WORD_RST;
      int_enable_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      instr_q <= instr_d;
      ac_out_q <= ac_out_d;
      biop1_q <= biop1_d;
      biop2_q <= biop2_d;
      biop4_q <= biop4_d;
      skip_acc_q <= skip_acc_d;
      data_acc_q <= data_acc_d;
      instr_ready_q <= instr_ready_d;
      done_q <= done_d;
      skip_q <= skip_d;
      acc_load_q <= acc_load_d;
      acc_in_q <= acc_in_d;
      int_jump_q <= int_jump_d;
      save_addr_q <= save_addr_d;
      save_data_q <= save_data_d;
      pc_load_q <= pc_load_d;
      int_enable_q <= int_enable_d;
    end
  end
endmodule

/* iob_periph.sv */
`timescale 1ns/1ns
module iob_periph #(
  parameter logic [5:0] DEV_CODE = 6'h01
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // bus side
  iob_if.periph bus,
  // device side
  input wire logic flag_set,
  input wire logic [11:0] dev_data,
  output logic flag_q,
  output logic wr_strobe_q,
  output logic [11:0] wr_data_q,
  output logic [2:0] sub_pulse_q,
  output logic [2:0] sub_code_q
);
  logic sel;
  logic b1_q, b2_q, b4_q;
  logic rise1, rise2, rise4;
  logic flag_d, wr_strobe_d;
  logic [11:0] wr_data_d;
  logic [2:0] sub_pulse_d, sub_code_d;
  logic skip_q, skip_d;
  logic [11:0] data_q, data_d;

  // only our own device code lets pulses in
  assign sel = (bus.instr[iob_pkg::DEV_MSB:iob_pkg::DEV_LSB] == DEV_CODE);
  assign rise1 = sel && bus.biop1 && !b1_q;
  assign rise2 = sel && bus.biop2 && !b2_q;
  assign rise4 = sel && bus.biop4 && !b4_q;
  assign bus.skip = skip_q;
  assign bus.data_in = data_q;
  assign bus.int_req = flag_q;

  // a new event in the clearing cycle survives: set beats clear
  always_comb begin
    flag_d = (flag_q && !rise2) || flag_set;
    skip_d = sel && bus.biop1 && flag_q;
    data_d = (sel && bus.biop4) ? dev_data : iob_pkg::WORD_RST;
    wr_strobe_d = rise4;
    wr_data_d = rise4 ? bus.ac_out : wr_data_q;
    sub_pulse_d = {rise4, rise2, rise1};
    sub_code_d = (rise1 || rise2 || rise4) ? bus.instr[2:0] : sub_code_q;
  end

  // registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      b1_q <= 1'b0;
      b2_q <= 1'b0;
      b4_q <= 1'b0;
      flag_q <= 1'b0;
      skip_q <= 1'b0;
      data_q <= iob_pkg::WORD_RST;
      wr_strobe_q <= 1'b0;
      wr_data_q <= iob_pkg::WORD_RST;
      sub_pulse_q <= 3'h0;
      sub_code_q <= 3'h0;
    end else begin
      b1_q <= sel && bus.biop1;
      b2_q <= sel && bus.biop2;
      b4_q <= sel && bus.biop4;
      flag_q <= flag_d;
      skip_q <= skip_d;
      data_q <= data_d;
      wr_strobe_q <= wr_strobe_d;
      wr_data_q <= wr_data_d;
      sub_pulse_q <= sub_pulse_d;
      sub_code_q <= sub_code_d;
    end
  end
endmodule

/* iob_props.sv */
`timescale 1ns/1ns
// bus watcher placed beside the interface joining the two ends
module iob_props #(
  parameter logic [5:0] DEV_CODE = 6'h05
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // bus signals
  input wire logic [11:0] instr,
  input wire logic biop1,
  input wire logic biop2,
  input wire logic biop4,
  input wire logic [11:0] data_in,
  input wire logic skip,
  input wire logic int_req
);
  localparam int PW = iob_pkg::IOP_WIDTH_CYC;
  localparam int GAP = iob_pkg::IOP_GAP_CYC;
  localparam int PW_M1 = PW - 1;
  localparam int PW_P1 = PW + 1;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // only one peripheral sits on this bus, so its code decides selection
  wire sel = instr[8:3] == DEV_CODE;

  // pulse generator properties
  property p_opcode;
    (biop1 || biop2 || biop4) |-> instr[11:9] == iob_pkg::IOT_OPCODE;
  endproperty
  property p_gate;
    (biop1 || biop2 || biop4) |-> (!biop1 || instr[iob_pkg::SEL_P1_BIT]) &&
      (!biop2 || instr[iob_pkg::SEL_P2_BIT]) && (!biop4 || instr[iob_pkg::SEL_P4_BIT]);
  endproperty
  property p_overlap;
    $onehot0({biop1, biop2, biop4});
  endproperty
  property p_p1_width;
    $rose(biop1) |-> ##PW_M1 biop1 ##1 !biop1;
  endproperty
  property p_p2_order;
    $fell(biop1) && instr[1] |-> ##GAP $rose(biop2);
  endproperty
  property p_p4_width;
    $fell(biop4) |-> $past(biop4, PW) && !$past(biop4, PW_P1);
  endproperty
  // peripheral answer properties
  property p_skip;
    skip |-> $past(biop1) && $past(int_req) && $past(sel);
  endproperty
  property p_data;
    data_in != 12'h000 |-> $past(biop4) && $past(sel);
  endproperty
  property p_flag_clr;
    $rose(biop2) && sel |-> ##[1:2] !int_req;
  endproperty

  a_opcode: assert property (p_opcode) else $error("pulse outside transfer");
  a_gate: assert property (p_gate) else $error("ungated pulse on bus");
  a_overlap: assert property (p_overlap) else $error("pulses overlap");
  a_p1_width: assert property (p_p1_width) else $error("first pulse width");
  a_p2_order: assert property (p_p2_order) else $error("second pulse timing");
  a_p4_width: assert property (p_p4_width) else $error("fourth pulse width");
  a_skip: assert property (p_skip) else $error("skip without cause");
  a_data: assert property (p_data) else $error("data outside pulse four");
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
  c_skip: cover property (skip);
  c_p4: cover property ($rose(biop4));
  c_data: cover property (data_in != 12'h000);
endmodule

/* io_bus_program_transfer_test.sv */
`timescale 1ns/1ns
module io_bus_program_transfer_test;
  localparam logic [5:0] DEV = 6'h05;
  // instruction words, octal 6051 6052 6054 6057 6061 6001 6002 1000
  localparam logic [11:0] SKP = 12'hc29, CLR = 12'hc2a, RDW = 12'hc2c, ALLP = 12'hc2f;
  localparam logic [11:0] OTH = 12'hc31, INT_ON_W = 12'hc01, INT_OFF_W = 12'hc02, NOP = 12'h200;
  localparam int IOT_LAT = 3 * (iob_pkg::IOP_WIDTH_CYC + iob_pkg::IOP_GAP_CYC) + 1;
  logic clock = 1'b0, nrst = 1'b0, instr_valid = 1'b0, alternate_mode = 1'b0, flag_set = 1'b0;
  logic [11:0] instr = 12'h000, pc = 12'h000, accumulator = 12'h000, dev_data = 12'h000;
  logic instr_ready_q, done_q, skip_q, acc_load_q, int_jump_q, int_enable_q, flag_q, wr_strobe_q;
  logic [11:0] acc_in_q, save_addr_q, save_data_q, pc_load_q, wr_data_q;
  logic [2:0] sub_pulse_q, sub_code_q, sub_seen;
  int error_cnt = 0, tests_run = 0, cyc = 0, lat = 0, jumps = 0, strobes = 0;

  iob_if bus ();
  iob_proc u_iob_proc (.clock, .nrst, .bus(bus), .instr_valid, .instr, .pc, .accumulator,
    .alternate_mode, .instr_ready_q, .done_q, .skip_q, .acc_load_q, .acc_in_q, .int_jump_q,
    .save_addr_q, .save_data_q, .pc_load_q, .int_enable_q);
  iob_periph #(.DEV_CODE(DEV)) u_iob_periph (.clock, .nrst, .bus(bus), .flag_set, .dev_data,
    .flag_q, .wr_strobe_q, .wr_data_q, .sub_pulse_q, .sub_code_q);
  iob_props #(.DEV_CODE(DEV)) u_iob_props (.clock, .nrst, .instr(bus.instr), .biop1(bus.biop1),
    .biop2(bus.biop2), .biop4(bus.biop4), .data_in(bus.data_in), .skip(bus.skip), .int_req(bus.int_req));

  // free-running 100 MHz clock
  always #5 clock = ~clock;
  // pulse counters and hang guard, sampled mid-cycle to stay off the launch edge
  always @(negedge clock) begin
    cyc++;
    if (int_jump_q === 1'b1) jumps++;
    if (wr_strobe_q === 1'b1) strobes++;
    sub_seen = sub_seen | sub_pulse_q;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // waits for ready, holds the request one accept edge, then times the answer
  task automatic issue(input logic [11:0] w);
    int n;
    n = 0;
    @(negedge clock);
    while (instr_ready_q !== 1'b1 && n < 500) begin
      @(negedge clock);
      n++;
    end
    chk("ready", 12'(instr_ready_q), 12'h001);
    instr = w;
    instr_valid = 1'b1;
    @(negedge clock);
    instr_valid = 1'b0;
    // done of a plain word stands only one cycle after accept, so look at once
    lat = 1;
    while (done_q !== 1'b1 && lat < 400) begin
      @(negedge clock);
      lat++;
    end
    chk("done", 12'(done_q), 12'h001);
  endtask
  task automatic pulse_flag();
    @(negedge clock);
    flag_set = 1'b1;
    @(negedge clock);
    flag_set = 1'b0;
  endtask

  task automatic t_skip();
    pulse_flag();
    issue(SKP);
    chk("skip", 12'(skip_q), 12'h001);
    chk("iot_lat", 12'(lat), 12'(IOT_LAT));
    chk("no_load", 12'(acc_load_q), 12'h000);
    issue(OTH);
    chk("other_skip", 12'(skip_q), 12'h000);
    issue(CLR);
    chk("flag_clr", 12'(flag_q), 12'h000);
    issue(SKP);
    chk("no_skip", 12'(skip_q), 12'h000);
  endtask
  task automatic t_xfer();
    int s;
    @(negedge clock);
    dev_data = 12'h5a3;
    accumulator = 12'h3c6;
    s = strobes;
    issue(RDW);
    chk("wr_strobe", 12'(strobes - s), 12'h001);
    chk("acc_load", 12'(acc_load_q), 12'h001);
    chk("acc_in", acc_in_q, 12'h5a3);
    chk("wr_data", wr_data_q, 12'h3c6);
    sub_seen = 3'h0;
    issue(ALLP);
    chk("sub_pulses", 12'(sub_seen), 12'h007);
    chk("sub_code", 12'(sub_code_q), 12'h007);
    issue(NOP);
    chk("plain_lat", 12'(lat), 12'h001);
  endtask
  // interrupt taken in the given mode lands on the given vectors
  task automatic t_int(input logic alt, input logic [11:0] sv, input logic [11:0] st);
    int n;
    issue(INT_ON_W);
    chk("int_on", 12'(int_enable_q), 12'h001);
    @(negedge clock);
    alternate_mode = alt;
    pc = 12'h123;
    pulse_flag();
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (int_jump_q !== 1'b1 && n < 20);
    chk("jump", 12'(int_jump_q), 12'h001);
    chk("save_addr", save_addr_q, sv);
    chk("pc_load", pc_load_q, st);
    chk("save_data", save_data_q, 12'h123);
    chk("en_clr", 12'(int_enable_q), 12'h000);
    issue(CLR);
  endtask
  task automatic t_off();
    int j;
    issue(INT_ON_W);
    issue(INT_OFF_W);
    chk("int_off", 12'(int_enable_q), 12'h000);
    pulse_flag();
    j = jumps;
    issue(NOP);
    chk("no_jump", 12'(jumps - j), 12'h000);
    issue(CLR);
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    t_skip();
    t_xfer();
    t_int(1'b0, 12'h000, 12'h001);
    t_int(1'b1, 12'h020, 12'h021);
    t_off();
    print_verdict();
  end
endmodule
